// ==== hdl/sdp_fifo.sv ====
`timescale 1ns/100ps
`default_nettype none
module sdp_fifo #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 8
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [WIDTH-1:0] in_data_in,
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [WIDTH-1:0] out_data_out
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [AW:0] DEPTH_L = (AW + 1)'(DEPTH);
	localparam logic [AW:0] PTR_ONE = (AW + 1)'(1);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW:0] wr_ptr_r;
	logic [AW:0] rd_ptr_r;
	logic [AW:0] fill;
	logic push;
	logic pop;

	assign fill = wr_ptr_r - rd_ptr_r;
	assign in_ready_out = (fill != DEPTH_L);
	assign out_valid_out = (fill != '0);
	assign push = in_valid_in & in_ready_out;
	assign pop = out_valid_out & out_ready_in;
	assign out_data_out = mem_r[rd_ptr_r[AW-1:0]];

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			wr_ptr_r <= '0;
		else if (push)
			wr_ptr_r <= (wr_ptr_r[AW-1:0] == AW'(DEPTH - 1)) ?
				{~wr_ptr_r[AW], {AW{1'b0}}} : wr_ptr_r + PTR_ONE;
	end

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			rd_ptr_r <= '0;
		else if (pop)
			rd_ptr_r <= (rd_ptr_r[AW-1:0] == AW'(DEPTH - 1)) ?
				{~rd_ptr_r[AW], {AW{1'b0}}} : rd_ptr_r + PTR_ONE;
	end

	always_ff @(posedge clk_in)
	begin
		if (push)
			mem_r[wr_ptr_r[AW-1:0]] <= in_data_in;
	end

endmodule // sdp_fifo
`default_nettype wire

// ==== hdl/sdp_pkg.sv ====
`default_nettype none
package sdp_pkg;

	// Frame and latch geometry
	localparam int WORD_BITS = 16;
	localparam int CODE_BITS = 12;
	localparam int DONT_CARE_BITS = 4;
	localparam int CNT_BITS = 5;
	localparam logic [CNT_BITS-1:0] CNT_ZERO = 5'h00;
	localparam logic [CNT_BITS-1:0] CNT_ONE = 5'h01;
	localparam logic [CNT_BITS-1:0] CNT_FULL = 5'h10;

	// Pin input conditioning
	localparam int SYNC_STAGES = 3;
	localparam int PIN_COUNT = 7;

	// Output word buffer
	localparam int FIFO_DEPTH = 8;

	// Reset values
	localparam logic [CODE_BITS-1:0] CODE_CLEARED = 12'h000;
	localparam logic [WORD_BITS-1:0] WORD_RESET = 16'h0000;

	// Code format select encodings
	localparam logic FMT_OFFSET_BINARY = 1'b0;
	localparam logic FMT_TWOS_COMPLEMENT = 1'b1;

	typedef enum logic [2:0] {
		SDP_IDLE = 3'b001,
		SDP_SHIFT = 3'b010,
		SDP_LOCKED = 3'b100
	} sdp_state_t;

	// Conditioned pin bundle, one bit per pin
	typedef struct packed {
		logic link_clock;
		logic frame_n;
		logic serial_data;
		logic latch_load_n;
		logic chain_mode_select;
		logic zero_force_n;
		logic code_format_select;
	} sdp_pins_t;

endpackage
`default_nettype wire

// ==== hdl/sdp_port.sv ====
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// RULE1: Shift one data bit per falling link clock
// RULE2: Host sends each word as sixteen bits
// RULE3: Frame low restarts the loading logic
// RULE4: Latch load falling edge updates converter latch; code delays it while the word buffer is full
// RULE5: Load held low: update on sixteenth edge; code delays it while the word buffer is full
// RULE6: Host ties chain select per system wiring
// RULE7: Chain mode enables output, shifts data out
// RULE8: Clear low forces output to cleared state
// RULE9: Format select: zero offset binary, one twos
// RULE10: Only last twelve bits reach the latch
// RULE11: Stand-alone mode accepts exactly sixteen bits
// RULE12: Clear loads latch with zeros, bypassing shifter
// RULE13: Clear outranks any pending latch load
module sdp_port #(
	parameter int WORD_BITS = sdp_pkg::WORD_BITS,
	parameter int CODE_BITS = sdp_pkg::CODE_BITS,
	parameter int FIFO_DEPTH = sdp_pkg::FIFO_DEPTH
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic link_clock_in,
	input wire logic frame_n_in,
	input wire logic serial_data_in,
	input wire logic latch_load_n_in,
	input wire logic chain_mode_select_in,
	input wire logic zero_force_n_in,
	input wire logic code_format_select_in,
	output logic chain_data_out,
	output logic chain_data_oe_out,
	output logic [CODE_BITS-1:0] dac_code_out,
	output logic code_format_out,
	output logic output_cleared_out,
	output logic word_complete_out,
	output logic auto_update_out,
	output logic [CODE_BITS-1:0] dac_word_out,
	output logic dac_valid_out,
	input wire logic dac_ready_in
);

	localparam int NP = sdp_pkg::PIN_COUNT;
	localparam int NS = sdp_pkg::SYNC_STAGES;

	sdp_pkg::sdp_pins_t pins_raw;
	sdp_pkg::sdp_pins_t pins_f;
	sdp_pkg::sdp_pins_t pins_prev_r;
	logic [NP-1:0] pins_filt_r;

	sdp_pkg::sdp_state_t state_r;
	sdp_pkg::sdp_state_t state_nxt;
	logic [sdp_pkg::CNT_BITS-1:0] count_r;
	logic [sdp_pkg::CNT_BITS-1:0] count_base;
	logic [sdp_pkg::CNT_BITS-1:0] count_nxt;
	logic [WORD_BITS-1:0] shift_r;
	logic [WORD_BITS-1:0] shift_nxt;
	logic chain_out_r;
	logic auto_r;
	logic auto_nxt;
	logic done_r;
	logic load_req_r;
	logic clear_push_r;
	logic [CODE_BITS-1:0] held_r;
	logic [CODE_BITS-1:0] latch_r;

	logic clk_fall;
	logic frame_fall;
	logic latch_load_n_fall;
	logic zero_fall;
	logic frame_low;
	logic chain_mode;
	logic clearing;
	logic shift_en;
	logic hit_full;
	logic auto_req;
	logic manual_req;
	logic push_valid;
	logic push_ready;
	logic push_ok;
	logic [CODE_BITS-1:0] push_data;

	// Pin bundle in struct order
	assign pins_raw = '{
		link_clock: link_clock_in,
		frame_n: frame_n_in,
		serial_data: serial_data_in,
		latch_load_n: latch_load_n_in,
		chain_mode_select: chain_mode_select_in,
		zero_force_n: zero_force_n_in,
		code_format_select: code_format_select_in
	};

	// Three-stage conditioning; a change counts once stages two and three agree
	genvar gi;
	generate
		for (gi = 0; gi < NP; gi++)
		begin : g_sync
			logic [NS-1:0] stg_r;
			always_ff @(posedge clk_in or negedge rst_n_in)
			begin
				if (!rst_n_in)
					stg_r <= '1;
				else
					stg_r <= {stg_r[NS-2:0], pins_raw[gi]};
			end
			always_ff @(posedge clk_in or negedge rst_n_in)
			begin
				if (!rst_n_in)
					pins_filt_r[gi] <= 1'b1;
				else if (stg_r[NS-2] == stg_r[NS-1])
					pins_filt_r[gi] <= stg_r[NS-1];
			end
		end
	endgenerate

	assign pins_f = pins_filt_r;

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			pins_prev_r <= '1;
		else
			pins_prev_r <= pins_f;
	end

	assign clk_fall = pins_prev_r.link_clock & ~pins_f.link_clock;
	assign frame_fall = pins_prev_r.frame_n & ~pins_f.frame_n;
	assign latch_load_n_fall = pins_prev_r.latch_load_n & ~pins_f.latch_load_n;
	assign zero_fall = pins_prev_r.zero_force_n & ~pins_f.zero_force_n;
	assign frame_low = ~pins_f.frame_n;
	assign chain_mode = pins_f.chain_mode_select; // RULE6
	assign clearing = ~pins_f.zero_force_n;

	// Frame start restarts the counter; an edge in the same cycle is bit one
	assign count_base = frame_fall ? sdp_pkg::CNT_ZERO : count_r; // RULE3
	assign shift_en = frame_low & clk_fall & (state_r != sdp_pkg::SDP_LOCKED) &
		(chain_mode | (count_base < sdp_pkg::CNT_FULL)); // RULE11 RULE7
	assign hit_full = shift_en & (count_base == sdp_pkg::CNT_FULL - sdp_pkg::CNT_ONE);
	assign auto_nxt = frame_fall ? ~pins_f.latch_load_n : auto_r;

	always_comb
	begin
		shift_nxt = shift_r;
		count_nxt = count_base;
		if (shift_en)
		begin
			shift_nxt = {shift_r[WORD_BITS-2:0], pins_f.serial_data}; // RULE1
			if (count_base != sdp_pkg::CNT_FULL)
				count_nxt = count_base + sdp_pkg::CNT_ONE;
		end
	end

	always_comb
	begin
		state_nxt = state_r;
		unique case (state_r)
			sdp_pkg::SDP_IDLE:
			begin
				if (frame_fall)
					state_nxt = sdp_pkg::SDP_SHIFT; // RULE3
			end
			sdp_pkg::SDP_SHIFT:
			begin
				if (!frame_low)
					state_nxt = sdp_pkg::SDP_IDLE;
				else if (hit_full && !chain_mode)
					state_nxt = sdp_pkg::SDP_LOCKED; // RULE11
			end
			sdp_pkg::SDP_LOCKED:
			begin
				if (!frame_low)
					state_nxt = sdp_pkg::SDP_IDLE;
			end
			default:
				state_nxt = sdp_pkg::SDP_IDLE;
		endcase
	end

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			state_r <= sdp_pkg::SDP_IDLE;
		else
			state_r <= state_nxt;
	end

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			shift_r <= sdp_pkg::WORD_RESET;
			count_r <= sdp_pkg::CNT_ZERO;
		end
		else
		begin
			shift_r <= shift_nxt;
			count_r <= count_nxt;
		end
	end

	// Chain output follows the bit leaving the top of the shifter
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			chain_out_r <= 1'b0;
		else if (shift_en && chain_mode)
			chain_out_r <= shift_r[WORD_BITS-1]; // RULE7
	end

	// Update mode sampled when the frame opens
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			auto_r <= 1'b0;
		else
			auto_r <= auto_nxt; // RULE5
	end

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			done_r <= 1'b0;
		else if (frame_fall)
			done_r <= hit_full;
		else if (hit_full)
			done_r <= 1'b1;
	end

	assign auto_req = hit_full & auto_nxt; // RULE5
	// A load strobe falling with the frame start selects auto mode, not a load
	assign manual_req = latch_load_n_fall & done_r & ~auto_nxt; // RULE4

	// Low twelve bits are the code; the leading four are ignored
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			held_r <= sdp_pkg::CODE_CLEARED;
		else if ((auto_req || manual_req) && !clearing)
			held_r <= shift_nxt[CODE_BITS-1:0]; // RULE10
	end

	// Load waits for room in the word buffer; clear cancels it
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			load_req_r <= 1'b0;
		else if (clearing)
			load_req_r <= 1'b0; // RULE13
		else if (auto_req || manual_req)
			load_req_r <= 1'b1;
		else if (push_ok && !clear_push_r)
			load_req_r <= 1'b0;
	end

	// One zero word is queued per clear
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			clear_push_r <= 1'b0;
		else if (zero_fall)
			clear_push_r <= 1'b1;
		else if (push_ok && clear_push_r)
			clear_push_r <= 1'b0;
	end

	assign push_valid = clear_push_r | (load_req_r & ~clearing);
	assign push_ok = push_valid & push_ready;
	assign push_data = clear_push_r ? sdp_pkg::CODE_CLEARED : held_r;

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			latch_r <= sdp_pkg::CODE_CLEARED;
		else if (clearing)
			latch_r <= sdp_pkg::CODE_CLEARED; // RULE8 RULE12 RULE13
		else if (push_ok)
			latch_r <= push_data; // RULE4 RULE5
	end

	sdp_fifo #(
		.WIDTH(CODE_BITS),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.in_valid_in(push_valid),
		.in_ready_out(push_ready),
		.in_data_in(push_data),
		.out_valid_out(dac_valid_out),
		.out_ready_in(dac_ready_in),
		.out_data_out(dac_word_out)
	);

	assign chain_data_out = chain_out_r;
	assign chain_data_oe_out = chain_mode; // RULE7
	assign dac_code_out = latch_r;
	assign code_format_out = pins_f.code_format_select; // RULE9
	assign output_cleared_out = clearing; // RULE8
	assign word_complete_out = done_r;
	assign auto_update_out = auto_r;

endmodule // sdp_port
`default_nettype wire

// ==== tb/sdp_host_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module sdp_host_model (
	input wire logic clk_in,
	output logic link_clock_out,
	output logic frame_n_out,
	output logic serial_data_out,
	output logic latch_load_n_out
);
	initial
	begin
		link_clock_out = 1'h1;
		frame_n_out = 1'h1;
		serial_data_out = 1'h0;
		latch_load_n_out = 1'h1;
	end
	task automatic half();
		repeat (8) @(negedge clk_in);
	endtask
	// Sends the low n bits of w, top bit first
	task automatic xfer(input logic [31:0] w, input int n, input logic auto_mode);
		latch_load_n_out = ~auto_mode;
		frame_n_out = 1'h0;
		for (int i = n - 1; i >= 0; i--)
		begin
			serial_data_out = w[i];
			half();
			link_clock_out = 1'h0;
			half();
			link_clock_out = 1'h1;
		end
		half();
		frame_n_out = 1'h1;
		serial_data_out = ~serial_data_out;
		latch_load_n_out = 1'h1;
		half();
	endtask
	task automatic load_pulse();
		latch_load_n_out = 1'h0;
		half();
		latch_load_n_out = 1'h1;
		half();
	endtask
endmodule // sdp_host_model
`default_nettype wire

// ==== tb/sdp_port_asserts.sv ====
`timescale 1ns/100ps
`default_nettype none
module sdp_port_asserts #(
	parameter int CODE_BITS = 12
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic link_clock_in,
	input wire logic chain_mode_select_in,
	input wire logic zero_force_n_in,
	input wire logic code_format_select_in,
	input wire logic dac_ready_in,
	input wire logic chain_data_out,
	input wire logic chain_data_oe_out,
	input wire logic [CODE_BITS-1:0] dac_code_out,
	input wire logic code_format_out,
	input wire logic output_cleared_out,
	input wire logic word_complete_out,
	input wire logic auto_update_out,
	input wire logic [CODE_BITS-1:0] dac_word_out,
	input wire logic dac_valid_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	property p_oe; $stable(chain_mode_select_in) [*8] |-> chain_data_oe_out == chain_mode_select_in;
	endproperty
	a_oe: assert property (p_oe) else $error("chain enable wrong");
	property p_fmt; $stable(code_format_select_in) [*8] |-> code_format_out == code_format_select_in;
	endproperty
	a_fmt: assert property (p_fmt) else $error("format out wrong");
	property p_clr; !zero_force_n_in [*8] |-> dac_code_out == '0 && output_cleared_out; endproperty
	a_clr: assert property (p_clr) else $error("clear not applied");
	property p_prio; output_cleared_out && $past(output_cleared_out) |-> dac_code_out == '0;
	endproperty
	a_prio: assert property (p_prio) else $error("load during clear");
	property p_upd; !$stable(dac_code_out) && !$past(output_cleared_out) |-> dac_valid_out;
	endproperty
	a_upd: assert property (p_upd) else $error("latch change without buffer word");
	property p_hold; dac_valid_out && !dac_ready_in |=> dac_valid_out && $stable(dac_word_out);
	endproperty
	a_hold: assert property (p_hold) else $error("buffer head dropped");
	property p_quiet; !chain_data_oe_out && $past(!chain_data_oe_out) |-> $stable(chain_data_out);
	endproperty
	a_quiet: assert property (p_quiet) else $error("chain out moved in stand-alone");
	property p_idle; ($stable(link_clock_in) && chain_data_oe_out) [*8] |=> $stable(chain_data_out);
	endproperty
	a_idle: assert property (p_idle) else $error("chain out moved without clock");
	c_auto: cover property (auto_update_out && word_complete_out);
	c_pop: cover property (dac_valid_out && dac_ready_in);
	c_clr: cover property (output_cleared_out);
endmodule // sdp_port_asserts
bind sdp_port sdp_port_asserts #(.CODE_BITS(CODE_BITS)) u_asserts (
	.clk_in(clk_in),
	.rst_n_in(rst_n_in),
	.link_clock_in(link_clock_in),
	.chain_mode_select_in(chain_mode_select_in),
	.zero_force_n_in(zero_force_n_in),
	.code_format_select_in(code_format_select_in),
	.dac_ready_in(dac_ready_in),
	.chain_data_out(chain_data_out),
	.chain_data_oe_out(chain_data_oe_out),
	.dac_code_out(dac_code_out),
	.code_format_out(code_format_out),
	.output_cleared_out(output_cleared_out),
	.word_complete_out(word_complete_out),
	.auto_update_out(auto_update_out),
	.dac_word_out(dac_word_out),
	.dac_valid_out(dac_valid_out)
);
`default_nettype wire

// ==== tb/serial_dac_input_port_bench.sv ====
`timescale 1ns/100ps
`default_nettype none
module serial_dac_input_port_bench;
	logic clk_in, rst_n_in, chain_mode_select_in, zero_force_n_in, code_format_select_in;
	logic dac_ready_in, chain_data_out, chain_data_oe_out, code_format_out, output_cleared_out;
	logic word_complete_out, auto_update_out, dac_valid_out;
	logic [sdp_pkg::CODE_BITS-1:0] dac_code_out, dac_word_out, cur;
	logic [sdp_pkg::CODE_BITS-1:0] q[$];
	wire link_clock_in, frame_n_in, serial_data_in, latch_load_n_in;
	logic [31:0] v;
	int bad_count = 0;
	int compares = 0;
	int nb;
	// Bit i of each mask belongs to frame case i
	localparam logic [4:0] CHAIN_CASES = 5'h14;
	localparam logic [4:0] AUTO_CASES = 5'h07;

	sdp_port dut (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.link_clock_in(link_clock_in),
		.frame_n_in(frame_n_in),
		.serial_data_in(serial_data_in),
		.latch_load_n_in(latch_load_n_in),
		.chain_mode_select_in(chain_mode_select_in),
		.zero_force_n_in(zero_force_n_in),
		.code_format_select_in(code_format_select_in),
		.chain_data_out(chain_data_out),
		.chain_data_oe_out(chain_data_oe_out),
		.dac_code_out(dac_code_out),
		.code_format_out(code_format_out),
		.output_cleared_out(output_cleared_out),
		.word_complete_out(word_complete_out),
		.auto_update_out(auto_update_out),
		.dac_word_out(dac_word_out),
		.dac_valid_out(dac_valid_out),
		.dac_ready_in(dac_ready_in)
	);
	sdp_host_model host (
		.clk_in(clk_in),
		.link_clock_out(link_clock_in),
		.frame_n_out(frame_n_in),
		.serial_data_out(serial_data_in),
		.latch_load_n_out(latch_load_n_in)
	);

	initial
	begin
		clk_in = 1'h0;
		forever #5 clk_in = ~clk_in;
	end

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic settle();
		repeat (8) @(negedge clk_in);
	endtask

	// Auto update takes the first sixteen bits even in chain mode
	function automatic logic [sdp_pkg::CODE_BITS-1:0] exp_code(input logic [31:0] w, input int n,
		input logic ch, input logic au);
		return w[((ch && !au) ? 0 : n - 16) +: sdp_pkg::CODE_BITS];
	endfunction

	task automatic print_verdict();
		$display("Compares %0d, mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial
	begin
		rst_n_in = 1'h0;
		chain_mode_select_in = 1'h0;
		zero_force_n_in = 1'h1;
		code_format_select_in = 1'h0;
		dac_ready_in = 1'h1;
		cur = '0;
		v = $urandom(31902);
		repeat (2) @(negedge clk_in);
		rst_n_in = 1'h1;
		settle();
		for (int i = 0; i < 4; i++)
		begin
			code_format_select_in = 1'($urandom);
			settle();
			chk("format", code_format_out, code_format_select_in);
		end
		$display("Test format done");
		for (int i = 0; i < 5; i++)
		begin
			chain_mode_select_in = CHAIN_CASES[i];
			settle();
			chk("chain_oe", chain_data_oe_out, CHAIN_CASES[i]);
			nb = CHAIN_CASES[i] ? 32 : (i == 1 ? 18 : 16);
			v = $urandom;
			host.xfer(v, nb, AUTO_CASES[i]);
			settle();
			chk("complete", word_complete_out, 1'h1);
			chk("auto", auto_update_out, AUTO_CASES[i]);
			if (!AUTO_CASES[i])
			begin
				chk("held", dac_code_out, cur);
				host.load_pulse();
				settle();
			end
			cur = exp_code(v, nb, CHAIN_CASES[i], AUTO_CASES[i]);
			chk("code", dac_code_out, cur);
			if (CHAIN_CASES[i])
				chk("chain_out", chain_data_out, v[16]);
		end
		$display("Test frames done");
		chain_mode_select_in = 1'h0;
		settle();
		host.xfer($urandom, 5, 1'h0);
		chk("short", word_complete_out, 1'h0);
		host.load_pulse();
		settle();
		chk("refused", dac_code_out, cur);
		$display("Test abort done");
		dac_ready_in = 1'h0;
		for (int i = 0; i < 9; i++)
		begin
			v = $urandom;
			host.xfer(v, 16, 1'h1);
			q.push_back(v[11:0]);
			if (i < 8)
				cur = v[11:0];
		end
		settle();
		chk("stalled", dac_code_out, cur);
		for (int k = 0; k < 80 && q.size() > 0; k++)
		begin
			if (dac_valid_out === 1'h1)
			begin
				chk("buffer", dac_word_out, q.pop_front());
				dac_ready_in = 1'h1;
			end
			@(negedge clk_in);
			dac_ready_in = 1'h0;
			@(negedge clk_in);
		end
		chk("drained", q.size(), 0);
		chk("empty", dac_valid_out, 1'h0);
		chk("late_load", dac_code_out, v[11:0]);
		$display("Test buffer done");
		dac_ready_in = 1'h1;
		zero_force_n_in = 1'h0;
		settle();
		chk("cleared", output_cleared_out, 1'h1);
		chk("zero", dac_code_out, sdp_pkg::CODE_CLEARED);
		host.xfer($urandom, 16, 1'h1);
		chk("priority", dac_code_out, sdp_pkg::CODE_CLEARED);
		zero_force_n_in = 1'h1;
		settle();
		chk("released", output_cleared_out, 1'h0);
		chk("stays_zero", dac_code_out, sdp_pkg::CODE_CLEARED);
		$display("Test clear done");
		print_verdict();
	end
endmodule // serial_dac_input_port_bench
`default_nettype wire
